// [design/mstsr_regs.sv]
// MAC slot timing, wake, beacon and transmit status register bank
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module mstsr_regs import mstsr_pkg::*; (
	input  wire logic              SYS_CLK,          // 200 MHz clock
	input  wire logic              RST,              // Sync reset, high
	input  wire logic [ADDR_W-1:0] REG_ADDR,         // Register address
	input  wire logic [DATA_W-1:0] REG_WDATA,        // Write data
	input  wire logic              REG_WR,           // Write strobe
	input  wire logic              REG_RD,           // Read strobe
	output logic      [DATA_W-1:0] REG_RDATA,        // Read data, next cycle
	input  wire logic              TXN_DONE,         // Normal FIFO sequence end
	input  wire logic              TXN_FAIL,         // Normal FIFO retries out
	input  wire logic [1:0]        TXN_RETRIES,      // Normal FIFO retries used
	input  wire logic              TX_CCA_BUSY,      // Channel busy at last try
	input  wire logic              GTS1_DONE,        // First slot FIFO end
	input  wire logic              GTS1_FAIL,        // First slot retries out
	input  wire logic              GTS1_SHORT,       // First slot time short
	input  wire logic              GTS2_DONE,        // Second slot FIFO end
	input  wire logic              GTS2_FAIL,        // Second slot retries out
	input  wire logic              GTS2_SHORT,       // Second slot time short
	input  wire logic              CFP_START,        // Free period begins
	input  wire logic              BEACON_FIFO_EVT,  // Beacon FIFO event
	input  wire logic              WAKE_EVT,         // Wake-up event
	input  wire logic              BEACON_START_EVT, // Beacon start event
	input  wire logic              RSSI_VALID,       // Symbol RSSI strobe
	input  wire logic [7:0]        RSSI_SAMPLE,      // Symbol RSSI value
	output logic      [3:0]        SECOND_SLOT_END,  // Slot two end
	output logic      [3:0]        THIRD_SLOT_END,   // Slot three end
	output logic      [3:0]        FOURTH_SLOT_END,  // Slot four end
	output logic      [3:0]        FIFTH_SLOT_END,   // Slot five end
	output logic      [3:0]        SIXTH_SLOT_END,   // Slot six end
	output logic      [6:0]        LONG_IFS_SYMBOLS, // Long spacing total
	output logic      [3:0]        VCO_SETTLE_TIME,  // Settle symbols
	output logic                   ACK_PENDING_FLAG, // Ack frame pending
	output logic                   GTS_ACTIVE_FIFO,  // 0 first, 1 second
	output logic                   GTS_ALT_STOPPED,  // Alternation halted
	output logic                   INSTANT_WAKE,     // Immediate wake mode
	output logic                   WAKE_REQ,         // Register wake pulse
	output logic      [5:0]        BEACON_INTERVAL,  // Beacon start interval
	output logic      [7:0]        SUPERFRAME_OFS,   // Superframe offset
	output logic                   BEACON_FIFO_IRQ,  // Masked beacon event
	output logic      [3:0]        RSSI_SYMBOLS,     // Averaging length
	output logic      [7:0]        RSSI_AVG,         // Averaged RSSI
	output logic                   RSSI_AVG_VALID,   // Average strobe
	output logic                   SLOT_FIFO_CLK_EN  // Slot FIFO clock enable
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [3:0] second_slot_end;
		logic [3:0] third_slot_end;
		logic [3:0] fourth_slot_end;
		logic [3:0] fifth_slot_end;
		logic [3:0] sixth_slot_end;
		logic [5:0] long_ifs_min;
		logic [3:0] vco_settle_time;
		logic [6:0] long_ifs_total;
		logic       gts_fifo_alternate;
		logic       ack_pending_flag;
		logic       instant_wake_enable;
		logic       register_wake_pulse;
		logic       wake_req;
		logic [5:0] beacon_start_interval;
		logic [7:0] sf_offset;
		logic [1:0] normal_fifo_retry_count;
		logic       channel_busy_flag;
		logic       first_gts_time_short;
		logic       second_gts_time_short;
		logic       first_gts_release_fail;
		logic       second_gts_release_fail;
		logic       normal_release_fail;
		logic       beacon_fifo_irq_mask;
		logic       wake_cause;
		logic       beacon_irq;
		logic [1:0] rssi_average_len;
		logic [3:0] rssi_symbols;
		logic       slot_fifo_clock_on;
		logic [7:0] rdata;
	} mstsr_regs_type;

	mstsr_regs_type r;
	mstsr_regs_type next_r;
	logic           wr_hit;
	logic           g1_done;
	logic           g2_done;
	logic [7:0]     rd_val;

	////////////////////////////////////////////////////////////////////////
	// Slot FIFO events count only while their clock runs
	assign g1_done = GTS1_DONE & r.slot_fifo_clock_on;
	assign g2_done = GTS2_DONE & r.slot_fifo_clock_on;

	always_comb begin
		next_r = r;
		wr_hit = REG_WR;
		rd_val = RDATA_NONE;
		next_r.wake_req = 1'b0;

		// Register writes; only writable fields are taken
		if (wr_hit) begin
			unique case (REG_ADDR)
				ADDR_END_2_3: begin
					next_r.third_slot_end = REG_WDATA[HI_MSB:HI_LSB];
					next_r.second_slot_end = REG_WDATA[LO_MSB:LO_LSB];
				end
				ADDR_END_4_5: begin
					next_r.fifth_slot_end = REG_WDATA[HI_MSB:HI_LSB];
					next_r.fourth_slot_end = REG_WDATA[LO_MSB:LO_LSB];
				end
				ADDR_END_6: begin
					// Upper nibble reserved, dropped
					next_r.sixth_slot_end = REG_WDATA[LO_MSB:LO_LSB];
				end
				ADDR_PEND_LIFS: begin
					next_r.long_ifs_min = REG_WDATA[LIFS_MSB:LIFS_LSB];
					next_r.gts_fifo_alternate = REG_WDATA[ALT_BIT];
					next_r.ack_pending_flag = REG_WDATA[ACKP_BIT];
				end
				ADDR_WAKE: begin
					next_r.instant_wake_enable = REG_WDATA[IWAKE_BIT];
					next_r.register_wake_pulse = REG_WDATA[RWAKE_BIT];
					next_r.beacon_start_interval = REG_WDATA[BEACON_START_INTERVAL_MSB:BEACON_START_INTERVAL_LSB];
					// Wake fires on the clearing write of a set bit
					if (r.register_wake_pulse && !REG_WDATA[RWAKE_BIT]) begin
						next_r.wake_req = 1'b1;
					end
				end
				ADDR_SF_OFFSET: begin
					next_r.sf_offset = REG_WDATA;
				end
				ADDR_BCN_CTRL: begin
					// Cause bit and low nibble not writable
					next_r.beacon_fifo_irq_mask = REG_WDATA[BMSK_BIT];
					next_r.rssi_average_len = REG_WDATA[RSSI_MSB:RSSI_LSB];
				end
				ADDR_GATE_CLK: begin
					next_r.slot_fifo_clock_on = REG_WDATA[CLK_ON_BIT];
				end
				ADDR_VCO: begin
					next_r.vco_settle_time = REG_WDATA[LO_MSB:LO_LSB];
				end
				default: begin
					// Status and unmapped addresses ignore writes
					next_r.rdata = r.rdata;
				end
			endcase
		end

		// Derived timing and length values, registered for the core
		next_r.long_ifs_total = {1'b0, r.long_ifs_min} + {3'h0, r.vco_settle_time};
		next_r.rssi_symbols = mstsr_rssi_count(r.rssi_average_len);

		// Transmit outcome capture, held until the next end on that FIFO; channel busy held until the next end on any FIFO
		if (TXN_DONE) begin
			next_r.normal_fifo_retry_count = TXN_RETRIES;
			next_r.normal_release_fail = TXN_FAIL;
		end
		if (g1_done) begin
			next_r.first_gts_release_fail = GTS1_FAIL;
			next_r.first_gts_time_short = GTS1_SHORT;
		end
		if (g2_done) begin
			next_r.second_gts_release_fail = GTS2_FAIL;
			next_r.second_gts_time_short = GTS2_SHORT;
		end
		if (TXN_DONE || g1_done || g2_done) begin
			next_r.channel_busy_flag = TX_CCA_BUSY;
		end

		// Beacon start wins if both wake causes arrive together
		if (BEACON_START_EVT) begin
			next_r.wake_cause = 1'b1;
		end else if (WAKE_EVT) begin
			next_r.wake_cause = 1'b0;
		end

		next_r.beacon_irq = BEACON_FIFO_EVT & ~r.beacon_fifo_irq_mask;

		// Read mux; reserved bits read zero
		unique case (REG_ADDR)
			ADDR_END_2_3: begin
				rd_val = {r.third_slot_end, r.second_slot_end};
			end
			ADDR_END_4_5: begin
				rd_val = {r.fifth_slot_end, r.fourth_slot_end};
			end
			ADDR_END_6: begin
				rd_val = {4'h0, r.sixth_slot_end};
			end
			ADDR_PEND_LIFS: begin
				rd_val = {r.long_ifs_min, r.gts_fifo_alternate, r.ack_pending_flag};
			end
			ADDR_WAKE: begin
				rd_val = {r.instant_wake_enable, r.register_wake_pulse, r.beacon_start_interval};
			end
			ADDR_SF_OFFSET: begin
				rd_val = r.sf_offset;
			end
			ADDR_TX_STATUS: begin
				rd_val = {r.normal_fifo_retry_count, r.channel_busy_flag,
					r.second_gts_time_short, r.first_gts_time_short,
					r.second_gts_release_fail, r.first_gts_release_fail,
					r.normal_release_fail};
			end
			ADDR_BCN_CTRL: begin
				rd_val = {r.beacon_fifo_irq_mask, r.wake_cause, r.rssi_average_len, 4'h0};
			end
			ADDR_GATE_CLK: begin
				rd_val = {4'h0, r.slot_fifo_clock_on, 3'h0};
			end
			ADDR_VCO: begin
				rd_val = {4'h0, r.vco_settle_time};
			end
			default: begin
				rd_val = RDATA_NONE;
			end
		endcase
		// Data stand one cycle only; zero otherwise
		next_r.rdata = REG_RD ? rd_val : RDATA_NONE;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			r <= '0;
			r.long_ifs_min <= RST_LONG_IFS;
			r.vco_settle_time <= RST_VCO;
			r.long_ifs_total <= 7'({1'b0, RST_LONG_IFS} + {3'h0, RST_VCO});
			r.rssi_average_len <= RST_RSSI_LEN;
			r.rssi_symbols <= mstsr_rssi_count(RST_RSSI_LEN);
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	mstsr_gts_alt u_alt (
		.clk       (SYS_CLK),
		.rst       (RST),
		.clk_on    (r.slot_fifo_clock_on),
		.alternate (r.gts_fifo_alternate),
		.cfp_start (CFP_START),
		.g1_done   (g1_done),
		.g1_fail   (GTS1_FAIL | GTS1_SHORT),
		.g2_done   (g2_done),
		.g2_fail   (GTS2_FAIL | GTS2_SHORT),
		.active    (GTS_ACTIVE_FIFO),
		.stopped   (GTS_ALT_STOPPED)
	);

	mstsr_rssi_avg u_rssi (
		.clk       (SYS_CLK),
		.rst       (RST),
		.len_code  (r.rssi_average_len),
		.smp_valid (RSSI_VALID),
		.smp       (RSSI_SAMPLE),
		.avg       (RSSI_AVG),
		.avg_valid (RSSI_AVG_VALID)
	);

	////////////////////////////////////////////////////////////////////////
	assign REG_RDATA = r.rdata;
	assign SECOND_SLOT_END = r.second_slot_end;
	assign THIRD_SLOT_END = r.third_slot_end;
	assign FOURTH_SLOT_END = r.fourth_slot_end;
	assign FIFTH_SLOT_END = r.fifth_slot_end;
	assign SIXTH_SLOT_END = r.sixth_slot_end;
	assign LONG_IFS_SYMBOLS = r.long_ifs_total;
	assign VCO_SETTLE_TIME = r.vco_settle_time;
	assign ACK_PENDING_FLAG = r.ack_pending_flag;
	assign INSTANT_WAKE = r.instant_wake_enable;
	assign WAKE_REQ = r.wake_req;
	assign BEACON_INTERVAL = r.beacon_start_interval;
	assign SUPERFRAME_OFS = r.sf_offset;
	assign BEACON_FIFO_IRQ = r.beacon_irq;
	assign RSSI_SYMBOLS = r.rssi_symbols;
	assign SLOT_FIFO_CLK_EN = r.slot_fifo_clock_on;
endmodule // mstsr_regs
`default_nettype wire

// [design/mstsr_pkg.sv]
// Constants and helpers for the MAC slot timing and status register bank
package mstsr_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] ADDR_END_2_3   = 8'h1E;
	localparam logic [7:0] ADDR_END_4_5   = 8'h1F;
	localparam logic [7:0] ADDR_END_6     = 8'h20;
	localparam logic [7:0] ADDR_PEND_LIFS = 8'h21;
	localparam logic [7:0] ADDR_WAKE      = 8'h22;
	localparam logic [7:0] ADDR_SF_OFFSET = 8'h23;
	localparam logic [7:0] ADDR_TX_STATUS = 8'h24;
	localparam logic [7:0] ADDR_BCN_CTRL  = 8'h25;
	localparam logic [7:0] ADDR_GATE_CLK  = 8'h26;
	localparam logic [7:0] ADDR_VCO       = 8'h3F;
	localparam logic [7:0] RDATA_NONE     = 8'h00;
	localparam logic [5:0] RST_LONG_IFS = 6'h21;
	localparam logic [3:0] RST_VCO      = 4'h7;
	localparam logic [1:0] RST_RSSI_LEN = 2'h3;
	localparam int HI_MSB = 7;
	localparam int HI_LSB = 4;
	localparam int LO_MSB = 3;
	localparam int LO_LSB = 0;
	localparam int LIFS_MSB = 7;
	localparam int LIFS_LSB = 2;
	localparam int ALT_BIT = 1;
	localparam int ACKP_BIT = 0;
	localparam int IWAKE_BIT = 7;
	localparam int RWAKE_BIT = 6;
	localparam int BEACON_START_INTERVAL_MSB = 5;
	localparam int BEACON_START_INTERVAL_LSB = 0;
	localparam int RETRY_MSB = 7;
	localparam int RETRY_LSB = 6;
	localparam int CCA_BIT = 5;
	localparam int G2_SHORT_BIT = 4;
	localparam int G1_SHORT_BIT = 3;
	localparam int G2_FAIL_BIT = 2;
	localparam int G1_FAIL_BIT = 1;
	localparam int N_FAIL_BIT = 0;
	localparam int BMSK_BIT = 7;
	localparam int CAUSE_BIT = 6;
	localparam int RSSI_MSB = 5;
	localparam int RSSI_LSB = 4;
	localparam int CLK_ON_BIT = 3;

	// Symbols averaged for a length code: 1, 2, 4 or 8
	function automatic logic [3:0] mstsr_rssi_count(input logic [1:0] code);
		mstsr_rssi_count = 4'h1 << code;
	endfunction
endpackage

// [design/mstsr_gts_alt.sv]
// Slot FIFO alternation between the first and second slot FIFOs
`timescale 1ns/1ps
`default_nettype none
module mstsr_gts_alt import mstsr_pkg::*; (
	input  wire logic clk,       // System clock
	input  wire logic rst,       // Synchronous reset
	input  wire logic clk_on,    // Slot FIFO clock enable
	input  wire logic alternate, // Keep toggling after failures
	input  wire logic cfp_start, // Free period begins
	input  wire logic g1_done,   // First slot FIFO finished
	input  wire logic g1_fail,   // First slot FIFO failed
	input  wire logic g2_done,   // Second slot FIFO finished
	input  wire logic g2_fail,   // Second slot FIFO failed
	output logic      active,    // 0 first FIFO, 1 second FIFO
	output logic      stopped    // Alternation halted
);
	typedef struct packed {
		logic active;
		logic stopped;
	} mstsr_alt_type;

	mstsr_alt_type r;
	mstsr_alt_type next_r;
	logic          done;
	logic          fail;

	always_comb begin
		next_r = r;
		done = active ? g2_done : g1_done;
		fail = active ? g2_fail : g1_fail;
		if (!clk_on) begin
			next_r = r;
		end else if (cfp_start) begin
			next_r.active = 1'b0;
			next_r.stopped = 1'b0;
		end else if (done && !r.stopped) begin
			if (fail && !alternate) begin
				next_r.stopped = 1'b1;
			end else begin
				next_r.active = ~r.active;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign active = r.active;
	assign stopped = r.stopped;
endmodule // mstsr_gts_alt
`default_nettype wire

// [design/mstsr_rssi_avg.sv]
// RSSI averager over 1, 2, 4 or 8 symbol samples
`timescale 1ns/1ps
`default_nettype none
module mstsr_rssi_avg import mstsr_pkg::*; (
	input  wire logic       clk,       // System clock
	input  wire logic       rst,       // Synchronous reset
	input  wire logic [1:0] len_code,  // Averaging length code
	input  wire logic       smp_valid, // One sample per symbol
	input  wire logic [7:0] smp,       // Sample value
	output logic      [7:0] avg,       // Averaged value
	output logic            avg_valid  // One-cycle result strobe
);
	typedef struct packed {
		logic [10:0] acc;
		logic [3:0]  cnt;
		logic [7:0]  avg;
		logic        valid;
	} mstsr_avg_type;

	mstsr_avg_type r;
	mstsr_avg_type next_r;
	logic [10:0]   sum;

	always_comb begin
		next_r = r;
		next_r.valid = 1'b0;
		sum = r.acc + {3'h0, smp};
		if (smp_valid) begin
			if (r.cnt + 4'h1 >= mstsr_rssi_count(len_code)) begin
				next_r.avg = 8'(sum >> len_code);
				next_r.valid = 1'b1;
				next_r.acc = '0;
				next_r.cnt = '0;
			end else begin
				next_r.acc = sum;
				next_r.cnt = r.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign avg = r.avg;
	assign avg_valid = r.valid;
endmodule // mstsr_rssi_avg
`default_nettype wire

// [bench/mstsr_host.sv]
// Host processor model for the register port
`timescale 1ns/1ps
`default_nettype none
module mstsr_host import mstsr_pkg::*; (
	input  wire logic              clk,   // System clock
	output logic      [ADDR_W-1:0] addr,  // Address
	output logic      [DATA_W-1:0] wdata, // Write data
	output logic                   wr,    // Write strobe
	output logic                   rd,    // Read strobe
	input  wire logic [DATA_W-1:0] rdata  // Read data
);
	initial begin
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data stand one cycle only, so take them mid-cycle
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	// A lone set never wakes; the clear completes it
	task automatic wake();
		wr_reg(ADDR_WAKE, 8'h40);
		wr_reg(ADDR_WAKE, 8'h00);
	endtask
endmodule // mstsr_host
`default_nettype wire

// [bench/mstsr_regs_asserts.sv]
// Port checks for the slot timing register bank
`timescale 1ns/1ps
`default_nettype none
module mstsr_regs_asserts import mstsr_pkg::*; (
	input wire logic       SYS_CLK,          // Clock
	input wire logic       RST,              // Reset
	input wire logic [7:0] REG_ADDR,         // Address
	input wire logic [7:0] REG_WDATA,        // Write data
	input wire logic       REG_WR,           // Write strobe
	input wire logic       REG_RD,           // Read strobe
	input wire logic [7:0] REG_RDATA,        // Read data
	input wire logic       GTS1_DONE,        // Slot one end
	input wire logic       GTS2_DONE,        // Slot two end
	input wire logic       CFP_START,        // Free period
	input wire logic       BEACON_FIFO_EVT,  // Beacon event
	input wire logic [3:0] SECOND_SLOT_END,  // Slot two end
	input wire logic [3:0] THIRD_SLOT_END,   // Slot three end
	input wire logic [6:0] LONG_IFS_SYMBOLS, // Long spacing
	input wire logic [3:0] VCO_SETTLE_TIME,  // Settle count
	input wire logic       ACK_PENDING_FLAG, // Ack pending
	input wire logic       GTS_ACTIVE_FIFO,  // Active FIFO
	input wire logic       GTS_ALT_STOPPED,  // Halted
	input wire logic       WAKE_REQ,         // Wake pulse
	input wire logic [7:0] SUPERFRAME_OFS,   // Offset
	input wire logic       BEACON_FIFO_IRQ,  // Beacon irq
	input wire logic [3:0] RSSI_SYMBOLS,     // Avg length
	input wire logic       RSSI_AVG_VALID,   // Avg strobe
	input wire logic       SLOT_FIFO_CLK_EN  // Clock enable
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	logic wr_lifs, wr_vco, wr_bcn;
	assign wr_lifs = REG_WR && REG_ADDR == ADDR_PEND_LIFS;
	assign wr_vco = REG_WR && REG_ADDR == ADDR_VCO;
	assign wr_bcn = REG_WR && REG_ADDR == ADDR_BCN_CTRL;
	////////////////////////////////////////
	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == RDATA_NONE)
		else $error("read data not idle");
	// Sum lags the field by one cycle
	a_lifs_sum: assert property (wr_lifs ##1 !wr_vco |=>
		LONG_IFS_SYMBOLS == {1'b0, $past(REG_WDATA[LIFS_MSB:LIFS_LSB], 2)} + {3'h0, VCO_SETTLE_TIME})
		else $error("long spacing total wrong");
	a_ack_follow: assert property (wr_lifs |=> ACK_PENDING_FLAG == $past(REG_WDATA[ACKP_BIT]))
		else $error("ack pending wrong");
	a_wake_cause: assert property (WAKE_REQ |->
		$past(REG_WR && REG_ADDR == ADDR_WAKE && !REG_WDATA[RWAKE_BIT]))
		else $error("wake pulse without clear");
	a_irq_cause: assert property (BEACON_FIFO_IRQ |-> $past(BEACON_FIFO_EVT))
		else $error("beacon irq without event");
	a_rssi_len: assert property (wr_bcn ##1 !wr_bcn |=>
		RSSI_SYMBOLS == (4'h1 << $past(REG_WDATA[RSSI_MSB:RSSI_LSB], 2)))
		else $error("rssi length wrong");
	a_clk_follow: assert property (REG_WR && REG_ADDR == ADDR_GATE_CLK |=>
		SLOT_FIFO_CLK_EN == $past(REG_WDATA[CLK_ON_BIT]))
		else $error("clock enable wrong");
	a_gated_hold: assert property (!SLOT_FIFO_CLK_EN && (GTS1_DONE || GTS2_DONE || CFP_START) |=>
		$stable(GTS_ACTIVE_FIFO) && $stable(GTS_ALT_STOPPED))
		else $error("alternation moved while gated");
	a_slot_ends: assert property (REG_WR && REG_ADDR == ADDR_END_2_3 |=>
		{THIRD_SLOT_END, SECOND_SLOT_END} == $past(REG_WDATA))
		else $error("slot ends wrong");
	a_offset_load: assert property (REG_WR && REG_ADDR == ADDR_SF_OFFSET |=>
		SUPERFRAME_OFS == $past(REG_WDATA))
		else $error("offset wrong");
	c_wake: cover property (WAKE_REQ);
	c_irq: cover property (BEACON_FIFO_IRQ);
	c_avg: cover property (RSSI_AVG_VALID);
	c_stop: cover property (GTS_ALT_STOPPED);
endmodule // mstsr_regs_asserts
bind mstsr_regs mstsr_regs_asserts mstsr_regs_asserts_i (.SYS_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR,
	.REG_RD, .REG_RDATA, .GTS1_DONE, .GTS2_DONE, .CFP_START, .BEACON_FIFO_EVT, .SECOND_SLOT_END,
	.THIRD_SLOT_END, .LONG_IFS_SYMBOLS, .VCO_SETTLE_TIME, .ACK_PENDING_FLAG, .GTS_ACTIVE_FIFO,
	.GTS_ALT_STOPPED, .WAKE_REQ, .SUPERFRAME_OFS, .BEACON_FIFO_IRQ, .RSSI_SYMBOLS, .RSSI_AVG_VALID,
	.SLOT_FIFO_CLK_EN);
`default_nettype wire

// [bench/mac_slot_timing_status_regs_tb.sv]
// Self-checking bench for the slot timing register bank
`timescale 1ns/1ps
`default_nettype none
module mac_slot_timing_status_regs_tb import mstsr_pkg::*;;
	logic       SYS_CLK, RST, REG_WR, REG_RD, RSSI_VALID;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, RSSI_SAMPLE, SUPERFRAME_OFS, RSSI_AVG;
	logic [1:0] TXN_RETRIES;
	wire logic  TXN_DONE, TXN_FAIL, TX_CCA_BUSY, GTS1_DONE, GTS1_FAIL, GTS1_SHORT, GTS2_DONE, GTS2_FAIL;
	wire logic  GTS2_SHORT, CFP_START, BEACON_FIFO_EVT, WAKE_EVT, BEACON_START_EVT;
	logic [3:0] SECOND_SLOT_END, THIRD_SLOT_END, FOURTH_SLOT_END, FIFTH_SLOT_END, SIXTH_SLOT_END;
	logic [3:0] VCO_SETTLE_TIME, RSSI_SYMBOLS;
	logic [6:0] LONG_IFS_SYMBOLS, ev;
	logic [5:0] BEACON_INTERVAL, q;
	logic       ACK_PENDING_FLAG, GTS_ACTIVE_FIFO, GTS_ALT_STOPPED, INSTANT_WAKE, WAKE_REQ;
	logic       BEACON_FIFO_IRQ, RSSI_AVG_VALID, SLOT_FIFO_CLK_EN;
	int         mismatches, checked, cyc;
	logic [7:0] ra [11] = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h3F, 8'h40};
	logic [7:0] r0 [11] = '{8'h00, 8'h00, 8'h00, 8'h84, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h07, 8'h00};
	logic [7:0] rf [11] = '{8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hB0, 8'h08, 8'h0F, 8'h00};
	logic [7:0] av [4] = '{8'h04, 8'h06, 8'h0A, 8'h12};
	assign {BEACON_START_EVT, WAKE_EVT, BEACON_FIFO_EVT, CFP_START, GTS2_DONE, GTS1_DONE, TXN_DONE} = ev;
	assign {GTS2_SHORT, GTS2_FAIL, GTS1_SHORT, GTS1_FAIL, TX_CCA_BUSY, TXN_FAIL} = q;
	mstsr_regs mstsr_regs_i (.SYS_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .TXN_DONE,
		.TXN_FAIL, .TXN_RETRIES, .TX_CCA_BUSY, .GTS1_DONE, .GTS1_FAIL, .GTS1_SHORT, .GTS2_DONE, .GTS2_FAIL,
		.GTS2_SHORT, .CFP_START, .BEACON_FIFO_EVT, .WAKE_EVT, .BEACON_START_EVT, .RSSI_VALID, .RSSI_SAMPLE,
		.SECOND_SLOT_END, .THIRD_SLOT_END, .FOURTH_SLOT_END, .FIFTH_SLOT_END, .SIXTH_SLOT_END,
		.LONG_IFS_SYMBOLS, .VCO_SETTLE_TIME, .ACK_PENDING_FLAG, .GTS_ACTIVE_FIFO, .GTS_ALT_STOPPED,
		.INSTANT_WAKE, .WAKE_REQ, .BEACON_INTERVAL, .SUPERFRAME_OFS, .BEACON_FIFO_IRQ, .RSSI_SYMBOLS,
		.RSSI_AVG, .RSSI_AVG_VALID, .SLOT_FIFO_CLK_EN);
	mstsr_host mstsr_host_i (.clk(SYS_CLK), .addr(REG_ADDR), .wdata(REG_WDATA), .wr(REG_WR), .rd(REG_RD),
		.rdata(REG_RDATA));
	////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		mstsr_host_i.rd_reg(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		mstsr_host_i.wr_reg(a, d);
	endtask
	// Outputs are judged mid-cycle after the taking edge
	task automatic fire(input logic [6:0] e, input logic [5:0] f, input logic [1:0] r);
		@(posedge SYS_CLK);
		ev <= e;
		q <= f;
		TXN_RETRIES <= r;
		@(posedge SYS_CLK);
		ev <= '0;
		@(negedge SYS_CLK);
	endtask
	task automatic do_reset();
		@(posedge SYS_CLK);
		RST <= 1'b1;
		repeat (10) @(posedge SYS_CLK);
		RST <= 1'b0;
	endtask
	task automatic t_reset();
		for (int i = 0; i < 11; i++) rc(ra[i], r0[i]);
		chk("lifs", 8'h28, 8'(LONG_IFS_SYMBOLS));
		chk("rssi len", 8'h08, 8'(RSSI_SYMBOLS));
	endtask
	task automatic t_access();
		for (int i = 0; i < 11; i++) wr(ra[i], 8'hFF);
		for (int i = 0; i < 11; i++) rc(ra[i], rf[i]);
		chk("slots", 8'hFF, {FIFTH_SLOT_END, FOURTH_SLOT_END});
		chk("slots23", 8'hFF, {THIRD_SLOT_END, SECOND_SLOT_END});
		chk("lifs", 8'h4E, 8'(LONG_IFS_SYMBOLS));
		chk("wake", 8'hFF, {INSTANT_WAKE, ACK_PENDING_FLAG, BEACON_INTERVAL});
		wr(ADDR_PEND_LIFS, 8'h7C);
		wr(ADDR_VCO, 8'h09);
		wr(ADDR_END_6, 8'h0F);
		wr(ADDR_SF_OFFSET, 8'h15);
		wr(ADDR_WAKE, 8'h00);
		@(negedge SYS_CLK);
		chk("lifs", 8'h28, 8'(LONG_IFS_SYMBOLS));
		chk("sixth", 8'h0F, 8'(SIXTH_SLOT_END));
		chk("offset", 8'h15, SUPERFRAME_OFS);
		chk("ack iw", 8'h00, {INSTANT_WAKE, ACK_PENDING_FLAG});
		chk("vco", 8'h09, 8'(VCO_SETTLE_TIME));
	endtask
	task automatic t_status();
		wr(ADDR_GATE_CLK, 8'h00);
		fire(7'h01, 6'h03, 2'h2);
		rc(ADDR_TX_STATUS, 8'hA1);
		fire(7'h02, 6'h04, 2'h0);
		rc(ADDR_TX_STATUS, 8'hA1);
		chk("alt", 8'h00, {GTS_ALT_STOPPED, GTS_ACTIVE_FIFO});
		wr(ADDR_GATE_CLK, 8'h08);
		fire(7'h02, 6'h08, 2'h0);
		rc(ADDR_TX_STATUS, 8'h89);
		chk("alt", 8'h02, {GTS_ALT_STOPPED, GTS_ACTIVE_FIFO});
		fire(7'h08, 6'h00, 2'h0);
		chk("alt", 8'h00, {GTS_ALT_STOPPED, GTS_ACTIVE_FIFO});
		wr(ADDR_PEND_LIFS, 8'h86);
		fire(7'h02, 6'h04, 2'h0);
		chk("alt", 8'h01, {GTS_ALT_STOPPED, GTS_ACTIVE_FIFO});
		fire(7'h04, 6'h32, 2'h0);
		chk("alt", 8'h00, {GTS_ALT_STOPPED, GTS_ACTIVE_FIFO});
		rc(ADDR_TX_STATUS, 8'hB7);
		fire(7'h01, 6'h00, 2'h1);
		rc(ADDR_TX_STATUS, 8'h56);
	endtask
	task automatic t_wake_irq();
		wr(ADDR_WAKE, 8'h40);
		@(negedge SYS_CLK);
		chk("lone set", 8'h00, 8'(WAKE_REQ));
		mstsr_host_i.wake();
		@(negedge SYS_CLK);
		chk("wake", 8'h01, 8'(WAKE_REQ));
		@(negedge SYS_CLK);
		chk("wake end", 8'h00, 8'(WAKE_REQ));
		wr(ADDR_BCN_CTRL, 8'h30);
		fire(7'h10, 6'h00, 2'h0);
		chk("irq", 8'h01, 8'(BEACON_FIFO_IRQ));
		wr(ADDR_BCN_CTRL, 8'hB0);
		fire(7'h10, 6'h00, 2'h0);
		chk("irq masked", 8'h00, 8'(BEACON_FIFO_IRQ));
		fire(7'h40, 6'h00, 2'h0);
		rc(ADDR_BCN_CTRL, 8'hF0);
		wr(ADDR_BCN_CTRL, 8'hBF);
		rc(ADDR_BCN_CTRL, 8'hF0);
		fire(7'h20, 6'h00, 2'h0);
		rc(ADDR_BCN_CTRL, 8'hB0);
	endtask
	task automatic t_rssi();
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_BCN_CTRL, 8'(c << 4));
			for (int i = 1; i <= (1 << c); i++) begin
				@(posedge SYS_CLK);
				RSSI_VALID <= 1'b1;
				RSSI_SAMPLE <= 8'(i * 4);
			end
			@(posedge SYS_CLK);
			RSSI_VALID <= 1'b0;
			@(negedge SYS_CLK);
			for (int k = 0; k < 4 && RSSI_AVG_VALID !== 1'b1; k++) @(negedge SYS_CLK);
			chk("avg valid", 8'h01, 8'(RSSI_AVG_VALID));
			chk("avg", av[c], RSSI_AVG);
			chk("rssi len", 8'(1 << c), 8'(RSSI_SYMBOLS));
		end
	endtask
	////////////////////////////////////////
	initial begin
		SYS_CLK = 1'b0;
		forever #2.5 SYS_CLK = ~SYS_CLK;
	end
	// Hang guard far beyond the few hundred cycles needed
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			close_out();
		end
	end
	initial begin
		RST = 1'b1;
		ev = '0;
		q = '0;
		TXN_RETRIES = 2'h0;
		RSSI_VALID = 1'b0;
		RSSI_SAMPLE = 8'h00;
		mismatches = 0;
		checked = 0;
		cyc = 0;
		do_reset();
		t_reset();
		t_access();
		t_status();
		t_wake_irq();
		t_rssi();
		do_reset();
		t_reset();
		close_out();
	end
endmodule // mac_slot_timing_status_regs_tb
`default_nettype wire
